// *** design/pid_regulator.sv ***
`timescale 1ns/10ps
module pid_regulator #(
	parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
)(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic [pid_pkg::PCT_W-1:0] ANALOG_VOLTAGE_IN,
	input wire logic [pid_pkg::PCT_W-1:0] ANALOG_CURRENT_IN,
	input wire logic [pid_pkg::PCT_W-1:0] COMM_SETPOINT,
	input wire logic [pid_pkg::PCT_W-1:0] COMM_FEEDBACK,
	input wire logic STEP_SEL_BIT0,
	input wire logic STEP_SEL_BIT1,
	input wire logic STEP_SEL_BIT2,
	input wire logic STEP_RUN,
	output logic [pid_pkg::FREQ_W-1:0] FREQ_CMD,
	output logic FREQ_CMD_EN,
	output logic STEP_ACTIVE,
	output logic [pid_pkg::FREQ_W-1:0] STEP_FREQ,
	output logic STEP_REVERSE,
	output logic FEEDBACK_LOSS
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	logic [2:0] freq_src_r, sp_src_r, fb_src_r;
	logic [pid_pkg::FREQ_W-1:0] max_freq_r, freq_r, step_freq_r;
	logic [pid_pkg::PCT_W-1:0] preset_sp_r, deadband_r, loss_level_r;
	logic polarity_r, fault_r, step_rev_r;
	logic [pid_pkg::GAIN_W-1:0] kp_r;
	logic [pid_pkg::TIME_W-1:0] ti_r, td_r, sample_r;
	logic [pid_pkg::LOSS_T_W-1:0] loss_time_r;
	logic [pid_pkg::STEP_W-1:0] step_r [pid_pkg::STEPS];
	logic [pid_pkg::LOSS_CNT_W-1:0] loss_cnt_r, loss_limit;
	logic signed [47:0] integ_r, u_r, p_term, integ_nxt, d_term, u_nxt;
	logic signed [47:0] ti_s, td_s, t_s;
	logic signed [11:0] err, prev_err_r, abs_err;
	logic [pid_pkg::PCT_W-1:0] setpoint, feedback, step_pos;
	logic [pid_pkg::STEP_W-1:0] step_val, step_mag;
	logic [10:0] fb_sum;
	logic [2:0] step_idx;
	logic pid_en, in_band, base_tick, period_tick;
	pid_pkg::calc_state_t state_r;
	logic [7:0] aw_addr_r, wr_addr;
	logic [31:0] w_data_r, wr_data, wr_mask, wr_word;
	logic [3:0] w_strb_r, strb_eff;
	logic aw_held_r, w_held_r, wr_fire;

	tick_divider #(
		.TICK_CYCLES(TICK_CYCLES),
		.PERIOD_W(pid_pkg::TIME_W)
	) u_tick (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.period(sample_r),
		.base_tick(base_tick),
		.period_tick(period_tick)
	);

	// Register read view, also used to merge partial writes
	function automatic logic [31:0] reg_word(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a[7:5] == pid_pkg::STEP_PAGE)
			v = 32'($signed(step_r[a[4:2]]));
		else
			unique case (a)
				pid_pkg::OFS_FREQ_SRC: v[2:0] = freq_src_r;
				pid_pkg::OFS_MAX_FREQ: v[15:0] = max_freq_r;
				pid_pkg::OFS_SP_SRC: v[2:0] = sp_src_r;
				pid_pkg::OFS_PRESET_SP: v[9:0] = preset_sp_r;
				pid_pkg::OFS_FB_SRC: v[2:0] = fb_src_r;
				pid_pkg::OFS_POLARITY: v[0] = polarity_r;
				pid_pkg::OFS_KP: v[13:0] = kp_r;
				pid_pkg::OFS_TI: v[13:0] = ti_r;
				pid_pkg::OFS_TD: v[13:0] = td_r;
				pid_pkg::OFS_SAMPLE: v[13:0] = sample_r;
				pid_pkg::OFS_DEADBAND: v[9:0] = deadband_r;
				pid_pkg::OFS_LOSS_LEVEL: v[9:0] = loss_level_r;
				pid_pkg::OFS_LOSS_TIME: v[15:0] = loss_time_r;
				pid_pkg::OFS_STATUS:
				begin
					v[pid_pkg::ST_FAULT_BIT] = fault_r;
					v[pid_pkg::ST_ACTIVE_BIT] = pid_en;
					v[pid_pkg::ST_STEP_BIT] = STEP_ACTIVE;
				end
				pid_pkg::OFS_FREQ_OUT: v[15:0] = freq_r;
				default: v = 32'h0000_0000;
			endcase
		return v;
	endfunction

	// Write channel steering: address and data are taken in either order
	assign AWREADY = !aw_held_r && !BVALID;
	assign WREADY = !w_held_r && !BVALID;
	assign wr_fire = (aw_held_r || AWVALID) && (w_held_r || WVALID) && !BVALID;
	assign wr_addr = {aw_held_r ? aw_addr_r[7:2] : AWADDR[7:2], 2'b00};
	assign wr_data = w_held_r ? w_data_r : WDATA;
	assign strb_eff = w_held_r ? w_strb_r : WSTRB;
	assign wr_mask = {{8{strb_eff[3]}}, {8{strb_eff[2]}},
		{8{strb_eff[1]}}, {8{strb_eff[0]}}};
	assign BRESP = 2'h0;
	assign RRESP = 2'h0;
	assign ARREADY = !RVALID;

	// A process, so the merge follows every register the view reads
	always_comb
	begin
		wr_word = (reg_word(wr_addr) & ~wr_mask) | (wr_data & wr_mask);
	end

	// Write handshake; response follows the cycle both halves are in
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			BVALID <= 1'b0;
		end
		else if (wr_fire)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			BVALID <= 1'b1;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= AWADDR;
			end
			if (WVALID && WREADY)
			begin
				w_held_r <= 1'b1;
				w_data_r <= WDATA;
				w_strb_r <= WSTRB;
			end
			if (BREADY)
				BVALID <= 1'b0;
		end
	end

	// Read channel; unmapped words read as zero with OKAY
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
		end
		else if (ARVALID && ARREADY)
		begin
			RVALID <= 1'b1;
			RDATA <= reg_word({ARADDR[7:2], 2'b00});
		end
		else if (RREADY)
			RVALID <= 1'b0;
	end

	// Configuration registers; values outside the ranges are not trapped
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			freq_src_r <= 3'h0;
			max_freq_r <= pid_pkg::MAX_FREQ_RST;
			sp_src_r <= pid_pkg::SP_KEYPAD;
			preset_sp_r <= pid_pkg::PRESET_RST;
			fb_src_r <= pid_pkg::FB_VOLTAGE;
			polarity_r <= 1'b0;
			kp_r <= pid_pkg::KP_RST;
			ti_r <= pid_pkg::TI_RST;
			td_r <= pid_pkg::TD_RST;
			sample_r <= pid_pkg::SAMPLE_RST;
			deadband_r <= pid_pkg::DEADBAND_RST;
			loss_level_r <= pid_pkg::LOSS_LEVEL_RST;
			loss_time_r <= pid_pkg::LOSS_TIME_RST;
		end
		else if (wr_fire)
			unique case (wr_addr)
				pid_pkg::OFS_FREQ_SRC: freq_src_r <= wr_word[2:0];
				pid_pkg::OFS_MAX_FREQ: max_freq_r <= wr_word[15:0];
				pid_pkg::OFS_SP_SRC: sp_src_r <= wr_word[2:0];
				pid_pkg::OFS_PRESET_SP: preset_sp_r <= wr_word[9:0];
				pid_pkg::OFS_FB_SRC: fb_src_r <= wr_word[2:0];
				pid_pkg::OFS_POLARITY: polarity_r <= wr_word[0];
				pid_pkg::OFS_KP: kp_r <= wr_word[13:0];
				pid_pkg::OFS_TI: ti_r <= wr_word[13:0];
				pid_pkg::OFS_TD: td_r <= wr_word[13:0];
				pid_pkg::OFS_SAMPLE: sample_r <= wr_word[13:0];
				pid_pkg::OFS_DEADBAND: deadband_r <= wr_word[9:0];
				pid_pkg::OFS_LOSS_LEVEL: loss_level_r <= wr_word[9:0];
				pid_pkg::OFS_LOSS_TIME: loss_time_r <= wr_word[15:0];
				default: ;
			endcase
	end

	// Step table, one register per entry
	genvar gi;
	generate
		for (gi = 0; gi < pid_pkg::STEPS; gi++)
		begin : g_step
			always_ff @(posedge SYS_CLK or negedge RST_N)
			begin
				if (!RST_N)
					step_r[gi] <= pid_pkg::STEP_RST;
				else if (wr_fire && wr_addr[7:5] == pid_pkg::STEP_PAGE
					&& wr_addr[4:2] == 3'(gi))
					step_r[gi] <= wr_word[pid_pkg::STEP_W-1:0];
			end
		end
	endgenerate

	// Step selection and setpoint/feedback routing
	assign step_idx = {STEP_SEL_BIT2, STEP_SEL_BIT1, STEP_SEL_BIT0};
	assign step_val = step_r[step_idx];
	assign step_mag = step_val[pid_pkg::STEP_W-1] ? -step_val : step_val;
	assign step_pos = step_val[pid_pkg::STEP_W-1] ? '0
		: step_val[pid_pkg::PCT_W-1:0];
	assign STEP_ACTIVE = STEP_RUN && (step_idx != 3'h0);
	assign fb_sum = {1'b0, ANALOG_VOLTAGE_IN} + {1'b0, ANALOG_CURRENT_IN};

	always_comb
	begin
		// Step entry outranks every other reference while active
		if (STEP_ACTIVE || sp_src_r == pid_pkg::SP_STEP)
			setpoint = step_pos;
		else
			unique case (sp_src_r)
				pid_pkg::SP_VOLTAGE: setpoint = ANALOG_VOLTAGE_IN;
				pid_pkg::SP_CURRENT: setpoint = ANALOG_CURRENT_IN;
				pid_pkg::SP_COMM: setpoint = COMM_SETPOINT;
				default: setpoint = preset_sp_r;
			endcase
		// Sum saturates at full scale, difference at zero
		unique case (fb_src_r)
			pid_pkg::FB_CURRENT: feedback = ANALOG_CURRENT_IN;
			pid_pkg::FB_SUM: feedback = (fb_sum > 11'(pid_pkg::PCT_FULL))
				? pid_pkg::PCT_FULL : fb_sum[pid_pkg::PCT_W-1:0];
			pid_pkg::FB_COMM: feedback = COMM_FEEDBACK;
			pid_pkg::FB_DIFF: feedback = (ANALOG_VOLTAGE_IN > ANALOG_CURRENT_IN)
				? ANALOG_VOLTAGE_IN - ANALOG_CURRENT_IN : '0;
			default: feedback = ANALOG_VOLTAGE_IN;
		endcase
	end

	function automatic logic signed [47:0] clamp(
		input logic signed [47:0] v, input logic signed [47:0] lo);
		if (v > pid_pkg::FULL_SCALE)
			return pid_pkg::FULL_SCALE;
		else if (v < lo)
			return lo;
		return v;
	endfunction

	// Error with polarity; terms in units of 1e-7 of max frequency
	assign pid_en = (freq_src_r == pid_pkg::FREQ_SRC_PID);
	assign err = polarity_r ? $signed({2'b00, feedback})
		- $signed({2'b00, setpoint})
		: $signed({2'b00, setpoint}) - $signed({2'b00, feedback});
	assign abs_err = err[11] ? -err : err;
	assign in_band = abs_err <= $signed({2'b00, deadband_r});
	assign ti_s = $signed({34'h0, (ti_r == '0) ? 14'h0001 : ti_r});
	assign t_s = $signed({34'h0, (sample_r == '0) ? 14'h0001 : sample_r});
	assign td_s = $signed({34'h0, td_r});
	assign p_term = 48'(err) * $signed({34'h0, kp_r});
	assign integ_nxt = clamp(integ_r + 48'(err) * pid_pkg::UNITS_PER_PERMILLE
		* t_s / ti_s, -pid_pkg::FULL_SCALE);
	assign d_term = 48'(err - prev_err_r) * pid_pkg::UNITS_PER_PERMILLE
		* td_s / t_s;
	assign u_nxt = clamp(p_term + integ_nxt + d_term, 48'sh0);

	// Sequencer: one calculation per sampling tick, then scaling
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			state_r <= pid_pkg::ST_IDLE;
		else
			unique case (state_r)
				pid_pkg::ST_IDLE: if (period_tick && pid_en)
					state_r <= pid_pkg::ST_CALC;
				pid_pkg::ST_CALC: state_r <= pid_pkg::ST_SCALE;
				pid_pkg::ST_SCALE: state_r <= pid_pkg::ST_IDLE;
				default: state_r <= pid_pkg::ST_IDLE;
			endcase
	end

	// Loop state; inside the deadband integral and output are frozen
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			integ_r <= 48'sh0;
			prev_err_r <= 12'sh000;
			u_r <= 48'sh0;
		end
		else if (state_r == pid_pkg::ST_CALC)
		begin
			prev_err_r <= err;
			if (!in_band)
			begin
				integ_r <= integ_nxt;
				u_r <= u_nxt;
			end
		end
	end

	// Frequency command; zeroed whenever PID is not the source
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			freq_r <= '0;
		else if (!pid_en)
			freq_r <= '0;
		else if (state_r == pid_pkg::ST_SCALE)
			freq_r <= 16'(u_r * $signed({32'h0, max_freq_r})
				/ pid_pkg::FULL_SCALE);
	end
	assign FREQ_CMD = freq_r;
	assign FREQ_CMD_EN = pid_en;

	// Step frequency output, sign gives direction
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			step_freq_r <= '0;
			step_rev_r <= 1'b0;
		end
		else
		begin
			step_freq_r <= 16'(({16'h0, 5'h0, step_mag} * {16'h0, max_freq_r})
				/ 32'(pid_pkg::PCT_FULL));
			step_rev_r <= step_val[pid_pkg::STEP_W-1];
		end
	end
	assign STEP_FREQ = step_freq_r;
	assign STEP_REVERSE = step_rev_r;

	// Feedback loss: runs always, restarts when feedback recovers
	assign loss_limit = loss_time_r * pid_pkg::TICKS_PER_LOSS_UNIT;
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			loss_cnt_r <= '0;
		else if (feedback > loss_level_r)
			loss_cnt_r <= '0;
		else if (base_tick && !(&loss_cnt_r))
			loss_cnt_r <= loss_cnt_r + 1'b1;
	end

	// Fault is sticky; a new detection wins over a software clear
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			fault_r <= 1'b0;
		else if (loss_cnt_r > loss_limit)
			fault_r <= 1'b1;
		else if (wr_fire && wr_addr == pid_pkg::OFS_STATUS && strb_eff[0]
			&& wr_data[pid_pkg::ST_FAULT_BIT])
			fault_r <= 1'b0;
	end
	assign FEEDBACK_LOSS = fault_r;

	property p_drive_gate;
		!pid_en |=> FREQ_CMD == '0;
	endproperty
	a_drive_gate: assert property (p_drive_gate)
		else $error("frequency driven while PID not selected");

	property p_clamp;
		state_r == pid_pkg::ST_SCALE |=> FREQ_CMD <= $past(max_freq_r);
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("frequency command above maximum");

	property p_calc_tick;
		state_r == pid_pkg::ST_IDLE && period_tick && pid_en
		|=> state_r == pid_pkg::ST_CALC ##1 state_r == pid_pkg::ST_SCALE
		##1 state_r == pid_pkg::ST_IDLE;
	endproperty
	a_calc_tick: assert property (p_calc_tick)
		else $error("sample tick did not start one calculation");

	property p_deadband;
		state_r == pid_pkg::ST_CALC && in_band
		|=> u_r == $past(u_r) && integ_r == $past(integ_r);
	endproperty
	a_deadband: assert property (p_deadband)
		else $error("output moved inside deadband");

	property p_integ_grow;
		state_r == pid_pkg::ST_CALC && !in_band && err > 0
		&& integ_r < pid_pkg::FULL_SCALE |=> integ_r > $past(integ_r);
	endproperty
	a_integ_grow: assert property (p_integ_grow)
		else $error("integral did not accumulate on error");

	property p_deriv_zero;
		state_r == pid_pkg::ST_CALC && !in_band && err == prev_err_r
		|=> u_r == clamp($past(p_term) + $past(integ_nxt), 48'sh0);
	endproperty
	a_deriv_zero: assert property (p_deriv_zero)
		else $error("derivative acted without error change");

	property p_loss_clear;
		feedback > loss_level_r |=> loss_cnt_r == '0;
	endproperty
	a_loss_clear: assert property (p_loss_clear)
		else $error("loss timer kept running on good feedback");

	property p_loss_rise;
		$rose(fault_r) |-> $past(loss_cnt_r) > $past(loss_limit);
	endproperty
	a_loss_rise: assert property (p_loss_rise)
		else $error("feedback loss raised before time elapsed");

	property p_step_prio;
		STEP_ACTIVE |-> setpoint == step_pos;
	endproperty
	a_step_prio: assert property (p_step_prio)
		else $error("step setpoint not given priority");

	c_fault: cover property ($rose(fault_r));
	c_calc_out_band: cover property (state_r == pid_pkg::ST_CALC && !in_band);
	c_step: cover property (STEP_ACTIVE && STEP_REVERSE);
	c_write: cover property (wr_fire && !aw_held_r && w_held_r);
endmodule

// *** design/tick_divider.sv ***
`timescale 1ns/10ps
module tick_divider #(
	parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES,
	parameter int PERIOD_W = pid_pkg::TIME_W
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [PERIOD_W-1:0] period,
	output logic base_tick,
	output logic period_tick
);
	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	logic [PRE_W-1:0] pre_r;
	logic [PERIOD_W-1:0] per_r;
	logic [PERIOD_W-1:0] period_eff;

	// A zero period would stall the loop, so it counts as one unit
	assign period_eff = (period == '0) ? PERIOD_W'(1) : period;

	// Prescaler down to the 0.01 s base tick
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_r <= '0;
			base_tick <= 1'b0;
		end
		else if (pre_r == PRE_W'(TICK_CYCLES - 1))
		begin
			pre_r <= '0;
			base_tick <= 1'b1;
		end
		else
		begin
			pre_r <= pre_r + 1'b1;
			base_tick <= 1'b0;
		end
	end

	// Sampling period in base ticks
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			per_r <= '0;
			period_tick <= 1'b0;
		end
		else if (base_tick && per_r >= period_eff - 1'b1)
		begin
			per_r <= '0;
			period_tick <= 1'b1;
		end
		else
		begin
			if (base_tick)
				per_r <= per_r + 1'b1;
			period_tick <= 1'b0;
		end
	end

	property p_period_after_base;
		@(posedge clk) disable iff (!rst_n)
		period_tick |-> $past(base_tick) && !base_tick;
	endproperty
	a_period_after_base: assert property (p_period_after_base)
		else $error("sampling tick not aligned to base tick");
endmodule

// *** pkg/pid_pkg.sv ***
package pid_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_TIME_NS = 10_000_000; // 0.01 s base tick
	localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam logic [3:0] TICKS_PER_LOSS_UNIT = 4'hA; // 0.1 s units

	// Field widths
	localparam int PCT_W = 10; // 0.1 % units, 0..1000
	localparam int STEP_W = 11; // signed 0.1 % units, -1000..1000
	localparam int GAIN_W = 14; // 0.0001 units
	localparam int TIME_W = 14; // 0.01 s units
	localparam int LOSS_T_W = 16; // 0.1 s units
	localparam int FREQ_W = 16; // 0.01 Hz units
	localparam int LOSS_CNT_W = 20;
	localparam int STEPS = 8;

	// Scaling: full output equals 10^7 internal units
	localparam logic [PCT_W-1:0] PCT_FULL = 10'h3E8;
	localparam logic signed [47:0] FULL_SCALE = 48'sh98_9680;
	localparam logic signed [47:0] UNITS_PER_PERMILLE = 48'sh2710;
	localparam logic signed [47:0] PERMILLE_FULL = 48'sh3E8;

	// Register byte offsets
	localparam logic [7:0] OFS_FREQ_SRC = 8'h00;
	localparam logic [7:0] OFS_MAX_FREQ = 8'h04;
	localparam logic [7:0] OFS_SP_SRC = 8'h08;
	localparam logic [7:0] OFS_PRESET_SP = 8'h0C;
	localparam logic [7:0] OFS_FB_SRC = 8'h10;
	localparam logic [7:0] OFS_POLARITY = 8'h14;
	localparam logic [7:0] OFS_KP = 8'h18;
	localparam logic [7:0] OFS_TI = 8'h1C;
	localparam logic [7:0] OFS_TD = 8'h20;
	localparam logic [7:0] OFS_SAMPLE = 8'h24;
	localparam logic [7:0] OFS_DEADBAND = 8'h28;
	localparam logic [7:0] OFS_LOSS_LEVEL = 8'h2C;
	localparam logic [7:0] OFS_LOSS_TIME = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam logic [7:0] OFS_FREQ_OUT = 8'h38;
	localparam logic [2:0] STEP_PAGE = 3'h2; // 0x40..0x5C

	// Status bit positions
	localparam int ST_FAULT_BIT = 0;
	localparam int ST_ACTIVE_BIT = 1;
	localparam int ST_STEP_BIT = 2;

	// Reset values
	localparam logic [FREQ_W-1:0] MAX_FREQ_RST = 16'h1388;
	localparam logic [GAIN_W-1:0] KP_RST = 14'h0064;
	localparam logic [TIME_W-1:0] TI_RST = 14'h000A;
	localparam logic [TIME_W-1:0] TD_RST = 14'h0000;
	localparam logic [TIME_W-1:0] SAMPLE_RST = 14'h000A;
	localparam logic [PCT_W-1:0] PRESET_RST = 10'h000;
	localparam logic [PCT_W-1:0] DEADBAND_RST = 10'h000;
	localparam logic [PCT_W-1:0] LOSS_LEVEL_RST = 10'h000;
	localparam logic [LOSS_T_W-1:0] LOSS_TIME_RST = 16'h000A;
	localparam logic [STEP_W-1:0] STEP_RST = 11'h000;

	typedef enum logic [2:0] {
		FREQ_SRC_PID = 3'b101
	} freq_src_t;

	typedef enum logic [2:0] {
		SP_KEYPAD = 3'b000,
		SP_VOLTAGE = 3'b001,
		SP_CURRENT = 3'b010,
		SP_COMM = 3'b011,
		SP_STEP = 3'b100
	} sp_src_t;

	typedef enum logic [2:0] {
		FB_VOLTAGE = 3'b000,
		FB_CURRENT = 3'b001,
		FB_SUM = 3'b010,
		FB_COMM = 3'b011,
		FB_DIFF = 3'b100
	} fb_src_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALC = 2'b01,
		ST_SCALE = 2'b10
	} calc_state_t;
endpackage

// *** verif/plant_model.sv ***
`timescale 1ns/10ps
module plant_model (
	input wire logic clk,
	input wire logic [pid_pkg::PCT_W-1:0] volt_lvl,
	input wire logic [pid_pkg::PCT_W-1:0] cur_lvl,
	output logic [pid_pkg::PCT_W-1:0] volt_out,
	output logic [pid_pkg::PCT_W-1:0] cur_out
);
	// Sensors read zero until the first sample reaches them
	initial
	begin
		volt_out = 10'h000;
		cur_out = 10'h000;
	end
	// One clock of transducer lag; a reading never exceeds full scale
	always @(posedge clk)
	begin
		volt_out <= (volt_lvl > pid_pkg::PCT_FULL) ? pid_pkg::PCT_FULL : volt_lvl;
		cur_out <= (cur_lvl > pid_pkg::PCT_FULL) ? pid_pkg::PCT_FULL : cur_lvl;
	end
endmodule

// *** verif/process_pid_multispeed_ref_tb.sv ***
`timescale 1ns/10ps
module process_pid_multispeed_ref_tb;
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [7:0] AWADDR = 8'h00;
	logic [7:0] ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h0000_0000;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic ARVALID = 1'b0, RREADY = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0] BRESP, RRESP;
	logic [31:0] RDATA, d;
	logic [9:0] volt = 10'h12C, cur = 10'h000, av, ac;
	logic [2:0] step_sel = 3'h0;
	logic step_run = 1'b0;
	logic [15:0] FREQ_CMD, STEP_FREQ;
	logic FREQ_CMD_EN, STEP_ACTIVE, STEP_REVERSE, FEEDBACK_LOSS;
	int error_cnt = 0, comparisons = 0, n, sv;
	int mx = int'(pid_pkg::MAX_FREQ_RST);
	logic [7:0] ra [9] = '{8'h04, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30, 8'h0C,
		8'h38, 8'h3C};
	logic [31:0] rv [9] = '{32'h0000_1388, 32'h0000_0064, 32'h0000_000A,
		32'h0000_0000, 32'h0000_000A, 32'h0000_000A, 32'h0, 32'h0, 32'h0};

	// Short tick so a base tick is ten clocks
	always #5 SYS_CLK = ~SYS_CLK;

	plant_model i_plant_model (.clk(SYS_CLK), .volt_lvl(volt), .cur_lvl(cur),
		.volt_out(av), .cur_out(ac));
	pid_regulator #(.TICK_CYCLES(10)) i_pid_regulator (.SYS_CLK(SYS_CLK),
		.RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .ANALOG_VOLTAGE_IN(av),
		.ANALOG_CURRENT_IN(ac), .COMM_SETPOINT(10'h000),
		.COMM_FEEDBACK(10'h000), .STEP_SEL_BIT0(step_sel[0]),
		.STEP_SEL_BIT1(step_sel[1]), .STEP_SEL_BIT2(step_sel[2]),
		.STEP_RUN(step_run), .FREQ_CMD(FREQ_CMD), .FREQ_CMD_EN(FREQ_CMD_EN),
		.STEP_ACTIVE(STEP_ACTIVE), .STEP_FREQ(STEP_FREQ),
		.STEP_REVERSE(STEP_REVERSE), .FEEDBACK_LOSS(FEEDBACK_LOSS));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	// Every wait is bounded so a hung handshake still reaches the report
	task automatic guard(inout int k);
		k++;
		if (k > 5000)
		begin
			error_cnt++;
			$display("BAD wait timed out");
			tally_and_finish();
		end
	endtask

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		logic aw_ok, w_ok;
		k = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge SYS_CLK);
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do
		begin
			@(posedge SYS_CLK);
			guard(k);
			if (!aw_ok && AWREADY)
			begin
				aw_ok = 1'b1;
				AWVALID <= 1'b0;
			end
			if (!w_ok && WREADY)
			begin
				w_ok = 1'b1;
				WVALID <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		do
		begin
			@(posedge SYS_CLK);
			guard(k);
		end while (BVALID !== 1'b1);
		BREADY <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		int k;
		k = 0;
		@(posedge SYS_CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do
		begin
			@(posedge SYS_CLK);
			guard(k);
		end while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do
		begin
			@(posedge SYS_CLK);
			guard(k);
		end while (RVALID !== 1'b1);
		v = RDATA;
		RREADY <= 1'b0;
	endtask

	// Waits for the next new command, counting the clocks it took
	task automatic wait_chg(output int k);
		logic [15:0] prev;
		k = 0;
		prev = FREQ_CMD;
		do
		begin
			@(posedge SYS_CLK);
			guard(k);
		end while (FREQ_CMD === prev);
	endtask

	initial
	begin
		repeat (6) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			rd(ra[i], d);
			chk("reset reg", d, rv[i]);
		end
		chk("cmd en idle", 32'(FREQ_CMD_EN), 32'h0);
		// Feedback loss: level 10 percent, time 0.1 s = 10 base ticks
		wr(pid_pkg::OFS_LOSS_LEVEL, 32'h0000_0064);
		wr(pid_pkg::OFS_LOSS_TIME, 32'h0000_0001);
		volt <= 10'h032;
		repeat (90) @(posedge SYS_CLK);
		chk("loss early", 32'(FEEDBACK_LOSS), 32'h0);
		repeat (40) @(posedge SYS_CLK);
		chk("loss set", 32'(FEEDBACK_LOSS), 32'h1);
		volt <= 10'h12C;
		// Let the timer see good feedback first; a live detection beats a clear
		repeat (3) @(posedge SYS_CLK);
		wr(pid_pkg::OFS_STATUS, 32'h0000_0001);
		@(posedge SYS_CLK);
		chk("loss clear", 32'(FEEDBACK_LOSS), 32'h0);
		// Every step code, signed entries on both sides of zero
		step_run <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			sv = i * 130 - 400;
			wr(8'h40 + 8'(i * 4), 32'(sv));
			step_sel <= 3'(i);
			repeat (4) @(posedge SYS_CLK);
			rd(8'h40 + 8'(i * 4), d);
			chk("step reg", d, 32'(sv));
			chk("step freq", 32'(STEP_FREQ), 32'((sv < 0 ? -sv : sv) * mx / 1000));
			chk("step rev", 32'(STEP_REVERSE), 32'(sv < 0));
			chk("step act", 32'(STEP_ACTIVE), 32'(i != 0));
		end
		step_run <= 1'b0;
		step_sel <= 3'h0;
		// Feedback above setpoint; keypad and voltage channels kept apart
		wr(pid_pkg::OFS_SAMPLE, 32'h0000_0001);
		wr(pid_pkg::OFS_PRESET_SP, 32'h0000_00C8);
		wr(pid_pkg::OFS_FREQ_SRC, 32'h0000_0005);
		repeat (100) @(posedge SYS_CLK);
		chk("cmd en", 32'(FREQ_CMD_EN), 32'h1);
		chk("pol pos", 32'(FREQ_CMD), 32'h0);
		wr(pid_pkg::OFS_POLARITY, 32'h0000_0001);
		n = 0;
		do
		begin
			@(posedge SYS_CLK);
			guard(n);
		end while (FREQ_CMD !== 16'(mx));
		repeat (30) @(posedge SYS_CLK);
		chk("pol neg", 32'(FREQ_CMD), 32'(mx));
		wr(pid_pkg::OFS_FREQ_SRC, 32'h0000_0000);
		@(posedge SYS_CLK);
		chk("src off", 32'(FREQ_CMD), 32'h0);
		// Second reset mid-run, then integral-only ramp on summed feedback
		RST_N <= 1'b0;
		repeat (6) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		volt <= 10'h032;
		cur <= 10'h032;
		wr(pid_pkg::OFS_FB_SRC, 32'h0000_0002);
		wr(pid_pkg::OFS_SAMPLE, 32'h0000_0001);
		wr(pid_pkg::OFS_KP, 32'h0000_0000);
		wr(pid_pkg::OFS_TI, 32'h0000_0001);
		wr(pid_pkg::OFS_PRESET_SP, 32'h0000_00C8);
		wr(pid_pkg::OFS_FREQ_SRC, 32'h0000_0005);
		wait_chg(n);
		chk("ramp 1", 32'(FREQ_CMD), 32'(mx / 10));
		wait_chg(n);
		chk("ramp 2", 32'(FREQ_CMD), 32'(mx / 5));
		chk("period", 32'(n), 32'h0000_000A);
		wr(pid_pkg::OFS_PRESET_SP, 32'h0000_0064);
		repeat (40) @(posedge SYS_CLK);
		chk("hold zero err", 32'(FREQ_CMD), 32'(mx / 5));
		wr(pid_pkg::OFS_DEADBAND, 32'h0000_0032);
		wr(pid_pkg::OFS_PRESET_SP, 32'h0000_0082);
		repeat (40) @(posedge SYS_CLK);
		chk("deadband hold", 32'(FREQ_CMD), 32'(mx / 5));
		wr(pid_pkg::OFS_PRESET_SP, 32'h0000_00B4);
		wait_chg(n);
		chk("deadband out", 32'(FREQ_CMD), 32'(mx * 7 / 25));
		// Derivative kick on a setpoint step, gone one sample later
		wr(pid_pkg::OFS_TD, 32'h0000_0001);
		wait_chg(n);
		chk("deriv base", 32'(FREQ_CMD), 32'(mx * 9 / 25));
		wr(pid_pkg::OFS_PRESET_SP, 32'h0000_0118);
		wait_chg(n);
		chk("deriv kick", 32'(FREQ_CMD), 32'(mx * 16 / 25));
		wait_chg(n);
		chk("deriv settle", 32'(FREQ_CMD), 32'(mx * 18 / 25));
		tally_and_finish();
	end
endmodule
